// >>> uepc_pkg.sv
// Shared constants for the USB endpoint control register block.
package uepc_pkg;
	// Register byte offsets on the Wishbone bus.
	localparam logic [7:0] ADDR_FRAME_START_THRESHOLD = 8'h00;
	localparam logic [7:0] ADDR_DESCRIPTOR_TABLE_PAGE = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS            = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK              = 8'h0C;
	localparam logic [7:0] ADDR_MODE_CONTROL          = 8'h10;
	localparam logic [7:0] ADDR_ENDPOINT_BASE         = 8'h40;
	localparam int         ADDR_BITS                  = 8;
	localparam int         EP_COUNT                   = 16;
	localparam int         EP_BITS                    = 4;
	// Endpoint control field positions.
	localparam int EP_LOW_SPEED_DIRECT_BIT   = 7;
	localparam int EP_NAK_RETRY_INHIBIT_BIT  = 6;
	localparam int EP_CONTROL_XFER_BLOCK_BIT = 4;
	localparam int EP_RECEIVE_ENABLE_BIT     = 3;
	localparam int EP_TRANSMIT_ENABLE_BIT    = 2;
	localparam int EP_STALL_FLAG_BIT         = 1;
	localparam int EP_HANDSHAKE_ENABLE_BIT   = 0;
	// Writable bits of the endpoint control and table page registers.
	localparam logic [7:0] EP_WRITE_MASK   = 8'hDD;
	localparam logic [7:0] PAGE_WRITE_MASK = 8'hFE;
	// Descriptor table base: page field feeds address bits 15 to 9.
	localparam int BDT_LOW_ZERO_BITS = 9;
	localparam int MODE_HOST_BIT     = 0;
	// Interrupt status bit positions.
	localparam int IRQ_STALL_BIT     = 0;
	localparam int IRQ_REFUSED_BIT   = 1;
	localparam int IRQ_FRAME_END_BIT = 2;
	localparam int IRQ_BITS          = 3;
	// Reset values.
	localparam logic [7:0] THRESHOLD_RESET = 8'h00;
	localparam logic [7:0] PAGE_RESET      = 8'h00;
	localparam logic [7:0] EP_RESET        = 8'h00;
	// Transaction kinds presented by the packet engine.
	typedef enum logic [1:0] {
		UEPC_KIND_OUT   = 2'b00,
		UEPC_KIND_IN    = 2'b01,
		UEPC_KIND_SETUP = 2'b10,
		UEPC_KIND_RSVD  = 2'b11
	} uepc_kind_e;
	// Bus slave states.
	typedef enum logic [1:0] {
		UEPC_BUS_IDLE = 2'b00,
		UEPC_BUS_READ = 2'b01,
		UEPC_BUS_ACK  = 2'b10
	} uepc_bus_e;
endpackage

// >>> uepc_ep_mem.sv
// Sixteen-entry endpoint control memory with two registered read ports.
`timescale 1ns/1ps
`default_nettype none
module uepc_ep_mem (
	input  wire logic       clk_i,     // System clock.
	input  wire logic       rst_i,     // Synchronous reset, active high.
	input  wire logic       wr_en_i,   // Write strobe.
	input  wire logic [3:0] wr_addr_i, // Write endpoint number.
	input  wire logic [7:0] wr_data_i, // Write data.
	input  wire logic [3:0] ra_addr_i, // Bus read endpoint number.
	output logic      [7:0] ra_data_o, // Bus read data, registered.
	input  wire logic [3:0] rb_addr_i, // Transaction read endpoint number.
	output logic      [7:0] rb_data_o  // Transaction read data, registered.
);
	logic [7:0] mem_reg [uepc_pkg::EP_COUNT];
	logic [7:0] mem_next [uepc_pkg::EP_COUNT];
	logic [7:0] ra_reg;
	logic [7:0] rb_reg;

	always_comb begin
		for (int i = 0; i < uepc_pkg::EP_COUNT; i++) begin
			mem_next[i] = mem_reg[i];
		end
		if (wr_en_i) begin
			mem_next[wr_addr_i] = wr_data_i & uepc_pkg::EP_WRITE_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < uepc_pkg::EP_COUNT; i++) begin
				mem_reg[i] <= uepc_pkg::EP_RESET;
			end
			ra_reg <= 8'h00;
			rb_reg <= 8'h00;
		end else begin
			for (int i = 0; i < uepc_pkg::EP_COUNT; i++) begin
				mem_reg[i] <= mem_next[i];
			end
			ra_reg <= mem_reg[ra_addr_i];
			rb_reg <= mem_reg[rb_addr_i];
		end
	end

	assign ra_data_o = ra_reg;
	assign rb_data_o = rb_reg;
endmodule
`default_nettype wire

// >>> uepc_frame_gate.sv
// Host-mode frame-end gate comparing remaining frame bytes to the threshold.
`timescale 1ns/1ps
`default_nettype none
module uepc_frame_gate (
	input  wire logic        clk_i,        // System clock.
	input  wire logic        rst_i,        // Synchronous reset, active high.
	input  wire logic        host_mode_i,  // Host mode selected.
	input  wire logic [7:0]  threshold_i,  // Frame threshold count in bytes.
	input  wire logic [15:0] bytes_left_i, // Bytes left before next frame start.
	output logic             permit_o      // New transaction may start.
);
	logic permit_reg;
	logic permit_next;

	always_comb begin
		permit_next = 1'b1;
		if (host_mode_i && (bytes_left_i < {8'h00, threshold_i})) begin
			permit_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			permit_reg <= 1'b1;
		end else begin
			permit_reg <= permit_next;
		end
	end

	assign permit_o = permit_reg;
endmodule
`default_nettype wire

// >>> uepc_top.sv
// USB endpoint control registers with Wishbone slave and transaction gating.
// Summary of operation
// - Table page field bits 7..1 give descriptor table address bits 15..9.
// - Descriptor table base is 512-byte aligned; low nine address bits are zero.
// - Endpoint 0 low-speed direct bit selects direct low-speed or hub with preamble.
// - Endpoint 0 retry-inhibit bit stops automatic hardware retry of NAKed transactions.
// - With both directions enabled, control-block bit refuses SETUP; otherwise ignored.
// - Receive transactions are accepted only while the receive enable bit is set.
// - Transmit transactions are performed only while the transmit enable bit is set.
// - Each endpoint's stall bit reads one when stalled, zero when not.
// - Handshake phases happen only while the endpoint handshake enable bit is set.
// - Bits 31..8 read zero; table page bit 0 reads zero.
// - Sixteen identical endpoint registers; speed and retry options matter on endpoint 0.
`timescale 1ns/1ps
`default_nettype none
module uepc_top (
	input  wire logic        clk_i,             // System clock, 100 MHz.
	input  wire logic        rst_i,             // Synchronous reset, active high.
	input  wire logic        wb_cyc_i,          // Wishbone cycle.
	input  wire logic        wb_stb_i,          // Wishbone strobe.
	input  wire logic        wb_we_i,           // Wishbone write enable.
	input  wire logic [7:0]  wb_adr_i,          // Wishbone byte address.
	input  wire logic [3:0]  wb_sel_i,          // Wishbone byte selects.
	input  wire logic [31:0] wb_dat_i,          // Wishbone write data.
	output logic      [31:0] wb_dat_o,          // Wishbone read data.
	output logic             wb_ack_o,          // Wishbone acknowledge.
	input  wire logic        xact_req_i,        // Transaction request pulse.
	input  wire logic [3:0]  xact_ep_i,         // Endpoint number of request.
	input  wire logic [1:0]  xact_kind_i,       // Request kind: OUT, IN, SETUP.
	input  wire logic [15:0] frame_bytes_left_i, // Bytes left before next frame start.
	input  wire logic        stall_set_i,       // Endpoint stalled event pulse.
	input  wire logic [3:0]  stall_ep_i,        // Endpoint number of stall event.
	output logic             xact_done_o,       // Decision valid pulse.
	output logic             xact_accept_o,     // Transaction may proceed.
	output logic             xact_stall_o,      // Endpoint is stalled.
	output logic             xact_handshake_o,  // Handshake phase enabled.
	output logic [31:0]      bdt_base_o,        // Descriptor table base address.
	output logic             low_speed_direct_o, // Host low-speed direct connection.
	output logic             nak_retry_inhibit_o, // Host NAK retry suppressed.
	output logic             host_mode_o,       // Host mode selected.
	output logic             irq_o              // Interrupt, level, active high.
);
	// Bus slave state.
	uepc_pkg::uepc_bus_e bus_state_reg;
	uepc_pkg::uepc_bus_e bus_state_next;
	logic                ack_reg;
	logic                ack_next;
	logic [31:0]         rdat_reg;
	logic [31:0]         rdat_next;

	// Software registers.
	logic [7:0]          threshold_reg;
	logic [7:0]          threshold_next;
	logic [7:0]          page_reg;
	logic [7:0]          page_next;
	logic [uepc_pkg::IRQ_BITS-1:0] irq_stat_reg;
	logic [uepc_pkg::IRQ_BITS-1:0] irq_stat_next;
	logic [uepc_pkg::IRQ_BITS-1:0] irq_mask_reg;
	logic [uepc_pkg::IRQ_BITS-1:0] irq_mask_next;
	logic                host_reg;
	logic                host_next;
	logic [15:0]         stall_reg;
	logic [15:0]         stall_next;
	logic                irq_reg;
	logic                irq_next;

	// Transaction pipeline.
	logic                xq_valid_reg;
	logic [3:0]          xq_ep_reg;
	logic [1:0]          xq_kind_reg;
	logic                done_reg;
	logic                done_next;
	logic                accept_reg;
	logic                accept_next;
	logic                stall_out_reg;
	logic                stall_out_next;
	logic                hshk_reg;
	logic                hshk_next;

	// Host outputs.
	logic [31:0]         base_reg;
	logic                lsd_reg;
	logic                retry_reg;

	// Decode and memory wires.
	logic                bus_req;
	logic                bus_wr;
	logic                is_ep;
	logic [3:0]          ep_index;
	logic                ep_wr;
	logic [7:0]          ep_bus_data;
	logic [7:0]          ep_xact_data;
	logic                permit;
	logic                access_go;
	logic [15:0]         stall_clr;

	// True when the byte address falls in the endpoint window.
	function automatic logic ep_hit(input logic [7:0] adr);
		ep_hit = (adr[7:6] == uepc_pkg::ADDR_ENDPOINT_BASE[7:6]) && (adr[1:0] == 2'b00);
	endfunction

	assign bus_req   = wb_cyc_i && wb_stb_i;
	assign access_go = (bus_state_reg == uepc_pkg::UEPC_BUS_READ);
	assign bus_wr    = access_go && wb_we_i && wb_sel_i[0];
	assign is_ep     = ep_hit(wb_adr_i);
	assign ep_index  = wb_adr_i[5:2];
	assign ep_wr     = bus_wr && is_ep;

	uepc_ep_mem u_mem (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (ep_wr),
		.wr_addr_i (ep_index),
		.wr_data_i (wb_dat_i[7:0]),
		.ra_addr_i (ep_index),
		.ra_data_o (ep_bus_data),
		.rb_addr_i (xact_ep_i),
		.rb_data_o (ep_xact_data)
	);

	uepc_frame_gate u_gate (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.host_mode_i  (host_reg),
		.threshold_i  (threshold_reg),
		.bytes_left_i (frame_bytes_left_i),
		.permit_o     (permit)
	);

	// Bus slave: request seen, one cycle for the memory read, then ack for one cycle.
	always_comb begin
		bus_state_next = bus_state_reg;
		ack_next       = 1'b0;
		rdat_next      = rdat_reg;
		unique case (bus_state_reg)
			uepc_pkg::UEPC_BUS_IDLE: begin
				if (bus_req) begin
					bus_state_next = uepc_pkg::UEPC_BUS_READ;
				end
			end
			uepc_pkg::UEPC_BUS_READ: begin
				bus_state_next = uepc_pkg::UEPC_BUS_ACK;
				ack_next       = 1'b1;
				rdat_next      = 32'h0000_0000;
				if (is_ep) begin
					rdat_next[7:0] = ep_bus_data;
					rdat_next[uepc_pkg::EP_STALL_FLAG_BIT] = stall_reg[ep_index];
				end else begin
					case (wb_adr_i)
						uepc_pkg::ADDR_FRAME_START_THRESHOLD: rdat_next[7:0] = threshold_reg;
						uepc_pkg::ADDR_DESCRIPTOR_TABLE_PAGE: begin
							rdat_next[7:0] = page_reg & uepc_pkg::PAGE_WRITE_MASK;
						end
						uepc_pkg::ADDR_IRQ_STATUS: rdat_next[uepc_pkg::IRQ_BITS-1:0] = irq_stat_reg;
						uepc_pkg::ADDR_IRQ_MASK:   rdat_next[uepc_pkg::IRQ_BITS-1:0] = irq_mask_reg;
						uepc_pkg::ADDR_MODE_CONTROL: rdat_next[uepc_pkg::MODE_HOST_BIT] = host_reg;
						default: rdat_next = 32'h0000_0000;
					endcase
				end
			end
			uepc_pkg::UEPC_BUS_ACK: begin
				bus_state_next = uepc_pkg::UEPC_BUS_IDLE;
			end
			default: begin
				bus_state_next = uepc_pkg::UEPC_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state_reg <= uepc_pkg::UEPC_BUS_IDLE;
			ack_reg       <= 1'b0;
			rdat_reg      <= 32'h0000_0000;
		end else begin
			bus_state_reg <= bus_state_next;
			ack_reg       <= ack_next;
			rdat_reg      <= rdat_next;
		end
	end

	// Software-written registers and the hardware stall flags.
	always_comb begin
		threshold_next = threshold_reg;
		page_next      = page_reg;
		irq_mask_next  = irq_mask_reg;
		host_next      = host_reg;
		stall_clr      = 16'h0000;
		if (bus_wr) begin
			if (is_ep && !wb_dat_i[uepc_pkg::EP_STALL_FLAG_BIT]) begin
				stall_clr[ep_index] = 1'b1;
			end
			case (wb_adr_i)
				uepc_pkg::ADDR_FRAME_START_THRESHOLD: threshold_next = wb_dat_i[7:0];
				uepc_pkg::ADDR_DESCRIPTOR_TABLE_PAGE: begin
					page_next = wb_dat_i[7:0] & uepc_pkg::PAGE_WRITE_MASK;
				end
				uepc_pkg::ADDR_IRQ_MASK: irq_mask_next = wb_dat_i[uepc_pkg::IRQ_BITS-1:0];
				uepc_pkg::ADDR_MODE_CONTROL: host_next = wb_dat_i[uepc_pkg::MODE_HOST_BIT];
				default: ;
			endcase
		end
		stall_next = stall_reg & ~stall_clr;
		if (stall_set_i) begin
			stall_next[stall_ep_i] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			threshold_reg <= uepc_pkg::THRESHOLD_RESET;
			page_reg      <= uepc_pkg::PAGE_RESET;
			irq_mask_reg  <= '0;
			host_reg      <= 1'b0;
			stall_reg     <= 16'h0000;
		end else begin
			threshold_reg <= threshold_next;
			page_reg      <= page_next;
			irq_mask_reg  <= irq_mask_next;
			host_reg      <= host_next;
			stall_reg     <= stall_next;
		end
	end

	// Transaction decision: endpoint data arrives one cycle after the request.
	always_comb begin
		done_next      = xq_valid_reg;
		accept_next    = 1'b0;
		stall_out_next = 1'b0;
		hshk_next      = 1'b0;
		if (xq_valid_reg) begin
			hshk_next      = ep_xact_data[uepc_pkg::EP_HANDSHAKE_ENABLE_BIT];
			stall_out_next = stall_reg[xq_ep_reg];
			unique case (xq_kind_reg)
				uepc_pkg::UEPC_KIND_OUT: begin
					accept_next = ep_xact_data[uepc_pkg::EP_RECEIVE_ENABLE_BIT];
				end
				uepc_pkg::UEPC_KIND_IN: begin
					accept_next = ep_xact_data[uepc_pkg::EP_TRANSMIT_ENABLE_BIT];
				end
				uepc_pkg::UEPC_KIND_SETUP: begin
					accept_next = ep_xact_data[uepc_pkg::EP_RECEIVE_ENABLE_BIT];
					if (ep_xact_data[uepc_pkg::EP_RECEIVE_ENABLE_BIT]
						&& ep_xact_data[uepc_pkg::EP_TRANSMIT_ENABLE_BIT]
						&& ep_xact_data[uepc_pkg::EP_CONTROL_XFER_BLOCK_BIT]) begin
						accept_next = 1'b0;
					end
				end
				default: accept_next = 1'b0;
			endcase
			if (!permit || stall_reg[xq_ep_reg]) begin
				accept_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xq_valid_reg  <= 1'b0;
			xq_ep_reg     <= 4'h0;
			xq_kind_reg   <= 2'b00;
			done_reg      <= 1'b0;
			accept_reg    <= 1'b0;
			stall_out_reg <= 1'b0;
			hshk_reg      <= 1'b0;
		end else begin
			xq_valid_reg  <= xact_req_i;
			xq_ep_reg     <= xact_ep_i;
			xq_kind_reg   <= xact_kind_i;
			done_reg      <= done_next;
			accept_reg    <= accept_next;
			stall_out_reg <= stall_out_next;
			hshk_reg      <= hshk_next;
		end
	end

	// Interrupt status: hardware set wins over a write-one clear in the same cycle.
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (bus_wr && (wb_adr_i == uepc_pkg::ADDR_IRQ_STATUS)) begin
			irq_stat_next = irq_stat_reg & ~wb_dat_i[uepc_pkg::IRQ_BITS-1:0];
		end
		if (stall_set_i) begin
			irq_stat_next[uepc_pkg::IRQ_STALL_BIT] = 1'b1;
		end
		if (xq_valid_reg && !accept_next) begin
			irq_stat_next[uepc_pkg::IRQ_REFUSED_BIT] = 1'b1;
		end
		if (xq_valid_reg && !permit) begin
			irq_stat_next[uepc_pkg::IRQ_FRAME_END_BIT] = 1'b1;
		end
		irq_next = |(irq_stat_next & irq_mask_next);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= '0;
			irq_reg      <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq_reg      <= irq_next;
		end
	end

	// Host-side options; speed and retry come from endpoint 0 only.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			base_reg  <= 32'h0000_0000;
			lsd_reg   <= 1'b0;
			retry_reg <= 1'b0;
		end else begin
			base_reg  <= {16'h0000, page_reg[7:1], {uepc_pkg::BDT_LOW_ZERO_BITS{1'b0}}};
			if (ep_wr && (ep_index == 4'h0)) begin
				lsd_reg   <= wb_dat_i[uepc_pkg::EP_LOW_SPEED_DIRECT_BIT] && host_reg;
				retry_reg <= wb_dat_i[uepc_pkg::EP_NAK_RETRY_INHIBIT_BIT] && host_reg;
			end else if (!host_reg) begin
				lsd_reg   <= 1'b0;
				retry_reg <= 1'b0;
			end
		end
	end

	assign wb_dat_o            = rdat_reg;
	assign wb_ack_o            = ack_reg;
	assign xact_done_o         = done_reg;
	assign xact_accept_o       = accept_reg;
	assign xact_stall_o        = stall_out_reg;
	assign xact_handshake_o    = hshk_reg;
	assign bdt_base_o          = base_reg;
	assign low_speed_direct_o  = lsd_reg;
	assign nak_retry_inhibit_o = retry_reg;
	assign host_mode_o         = host_reg;
	assign irq_o               = irq_reg;
endmodule
`default_nettype wire

// >>> uepc_chk.sv
// Port-level assertions for the USB endpoint control register block.
`timescale 1ns/1ps
`default_nettype none
module uepc_chk (
	input wire logic        clk_i,               // Clock.
	input wire logic        rst_i,               // Reset.
	input wire logic        wb_cyc_i,            // Bus cycle.
	input wire logic        wb_stb_i,            // Bus strobe.
	input wire logic        wb_we_i,             // Bus write.
	input wire logic [7:0]  wb_adr_i,            // Bus address.
	input wire logic [31:0] wb_dat_o,            // Read data.
	input wire logic        wb_ack_o,            // Acknowledge.
	input wire logic        xact_req_i,          // Request.
	input wire logic [1:0]  xact_kind_i,         // Request kind.
	input wire logic        xact_done_o,         // Decision valid.
	input wire logic        xact_accept_o,       // Accepted.
	input wire logic        xact_stall_o,        // Stalled.
	input wire logic        xact_handshake_o,    // Handshake.
	input wire logic [31:0] bdt_base_o,          // Table base.
	input wire logic        low_speed_direct_o,  // Low-speed direct.
	input wire logic        nak_retry_inhibit_o, // Retry inhibit.
	input wire logic        host_mode_o          // Host mode.
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_page_read_back: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i == uepc_pkg::ADDR_DESCRIPTOR_TABLE_PAGE |->
		wb_dat_o[7:0] == {bdt_base_o[15:9], 1'b0})
		else $error("page read does not match table base");
	a_base_aligned: assert property (bdt_base_o[8:0] == 9'h0 && bdt_base_o[31:16] == 16'h0)
		else $error("table base not aligned");
	a_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o ##2 wb_ack_o)
		else $error("ack not two cycles after request");
	a_done_latency: assert property (xact_req_i |-> ##2 xact_done_o)
		else $error("decision not two cycles after request");
	a_done_has_cause: assert property (xact_done_o |-> $past(xact_req_i, 2))
		else $error("decision without request");
	a_kind_reserved: assert property (xact_req_i && xact_kind_i == 2'b11 |-> ##2 !xact_accept_o)
		else $error("reserved kind accepted");
	a_stall_refuses: assert property (xact_done_o && xact_stall_o |-> !xact_accept_o)
		else $error("stalled endpoint accepted");
	a_quiet_idle: assert property (!xact_done_o |->
		!(xact_accept_o || xact_stall_o || xact_handshake_o))
		else $error("decision outputs active without done");
	a_host_only_opts: assert property (!host_mode_o && !$past(host_mode_o) |->
		!low_speed_direct_o && !nak_retry_inhibit_o)
		else $error("host options active outside host mode");
endmodule
bind uepc_top uepc_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_o, .wb_ack_o, .xact_req_i, .xact_kind_i, .xact_done_o, .xact_accept_o,
	.xact_stall_o, .xact_handshake_o, .bdt_base_o, .low_speed_direct_o,
	.nak_retry_inhibit_o, .host_mode_o);
`default_nettype wire

// >>> uepc_usb_peer.sv
// Packet engine model that presents transaction requests and stall events.
`timescale 1ns/1ps
`default_nettype none
module uepc_usb_peer (
	input  wire logic        clk_i,  // Clock.
	input  wire logic        go_i,   // Issue a request.
	input  wire logic [3:0]  ep_i,   // Endpoint number.
	input  wire logic [1:0]  kind_i, // Request kind.
	input  wire logic [15:0] left_i, // Frame bytes left.
	input  wire logic        st_i,   // Stall event.
	output logic             req_o,  // Request pulse.
	output logic      [3:0]  ep_o,   // Endpoint number.
	output logic      [1:0]  kind_o, // Request kind.
	output logic      [15:0] left_o, // Frame bytes left.
	output logic             st_o    // Stall pulse.
);
	initial begin
		req_o = 1'b0;
		ep_o = 4'h0;
		kind_o = 2'h0;
		left_o = 16'h0;
		st_o = 1'b0;
	end
	// Idle qualifiers toggle so that a stale value is never mistaken for a request.
	always @(posedge clk_i) begin
		req_o <= go_i;
		st_o <= st_i;
		left_o <= left_i;
		ep_o <= (go_i || st_i) ? ep_i : ~ep_o;
		kind_o <= go_i ? kind_i : ~kind_o;
	end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the USB endpoint control register block.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, p_go, p_st, irq_o;
	logic        xact_req_i, xact_done_o, xact_accept_o, xact_stall_o, xact_handshake_o;
	logic        low_speed_direct_o, nak_retry_inhibit_o, host_mode_o, stall_set_i;
	logic [7:0]  wb_adr_i, t;
	logic [3:0]  wb_sel_i, p_ep, xact_ep_i;
	logic [1:0]  p_kind, xact_kind_i;
	logic [15:0] p_left, frame_bytes_left_i;
	logic [31:0] wb_dat_i, wb_dat_o, bdt_base_o, wd;
	logic [31:0] rq[$], xq[$];
	int          errors, n_tests;

	uepc_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .xact_req_i, .xact_ep_i, .xact_kind_i,
		.frame_bytes_left_i, .stall_set_i, .stall_ep_i(xact_ep_i), .xact_done_o,
		.xact_accept_o, .xact_stall_o, .xact_handshake_o, .bdt_base_o, .low_speed_direct_o,
		.nak_retry_inhibit_o, .host_mode_o, .irq_o);
	uepc_usb_peer peer_u (.clk_i, .go_i(p_go), .ep_i(p_ep), .kind_i(p_kind), .left_i(p_left),
		.st_i(p_st), .req_o(xact_req_i), .ep_o(xact_ep_i), .kind_o(xact_kind_i),
		.left_o(frame_bytes_left_i), .st_o(stall_set_i));

	always #5 clk_i = ~clk_i;

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic end_sim();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			errors++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic tx(input logic [3:0] ep, input logic [1:0] k, input logic [2:0] e);
		xq.push_back({29'h0, e});
		p_go <= 1'b1;
		p_ep <= ep;
		p_kind <= k;
		@(posedge clk_i);
	endtask

	task automatic idle(input int n);
		p_go <= 1'b0;
		p_st <= 1'b0;
		repeat (n) @(posedge clk_i);
	endtask

	function automatic logic [7:0] ea(input int n);
		return 8'(uepc_pkg::ADDR_ENDPOINT_BASE + 4 * n);
	endfunction

	function automatic logic ok(input int k, input int v);
		return k == 0 ? v[2] : k == 1 ? v[1] : k == 2 ? v[2] && !(v[1] && v[3]) : 1'b0;
	endfunction

	// Results are matched against the oldest expectation noted by the driver.
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			chk(wb_dat_o, rq.pop_front());
		if (xact_done_o === 1'b1)
			chk({29'h0, xact_accept_o, xact_stall_o, xact_handshake_o}, xq.pop_front());
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		end_sim();
	end

	initial begin
		void'($urandom(32'hB7263F94));
		{errors, n_tests} = 0;
		{clk_i, wb_cyc_i, wb_stb_i, wb_we_i, p_go, p_st} = 0;
		{wb_adr_i, wb_sel_i, wb_dat_i, p_ep, p_kind, p_left} = 0;
		rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
		rd(ea(15), 32'h0);
		wd = $urandom;
		bus(1'b1, uepc_pkg::ADDR_DESCRIPTOR_TABLE_PAGE, wd);
		rd(uepc_pkg::ADDR_DESCRIPTOR_TABLE_PAGE, {24'h0, wd[7:1], 1'b0});
		chk(bdt_base_o, {16'h0, wd[7:1], 9'h0});
		for (int v = 0; v < 16; v++) begin
			wd = $urandom;
			wd[4:2] = v[3:1];
			wd[0] = v[0];
			bus(1'b1, ea(v), wd);
			rd(ea(v), {24'h0, wd[7:0] & uepc_pkg::EP_WRITE_MASK});
			for (int k = 0; k < 4; k++) tx(v[3:0], k[1:0], {ok(k, v), 1'b0, v[0]});
			idle(5);
		end
		bus(1'b1, ea(3), 32'h0D);
		p_st <= 1'b1;
		p_ep <= 4'h3;
		@(posedge clk_i);
		idle(3);
		rd(ea(3), 32'h0F);
		tx(4'h3, 2'h0, 3'b011);
		idle(5);
		rd(uepc_pkg::ADDR_IRQ_STATUS, 32'h3);
		chk({31'h0, irq_o}, 32'h0);
		bus(1'b1, uepc_pkg::ADDR_IRQ_MASK, 32'h1);
		idle(2);
		chk({31'h0, irq_o}, 32'h1);
		bus(1'b1, uepc_pkg::ADDR_IRQ_STATUS, 32'h1);
		idle(2);
		chk({31'h0, irq_o}, 32'h0);
		bus(1'b1, ea(3), 32'h0D);
		tx(4'h3, 2'h0, 3'b101);
		idle(5);
		bus(1'b1, uepc_pkg::ADDR_MODE_CONTROL, 32'h1);
		bus(1'b1, ea(0), 32'hCD);
		idle(2);
		chk({29'h0, host_mode_o, low_speed_direct_o, nak_retry_inhibit_o}, 32'h7);
		bus(1'b1, ea(0), 32'h4D);
		idle(2);
		chk({29'h0, host_mode_o, low_speed_direct_o, nak_retry_inhibit_o}, 32'h5);
		bus(1'b1, uepc_pkg::ADDR_IRQ_MASK, 32'h4);
		for (int i = 0; i < 3; i++) begin
			t = i == 0 ? 8'h4A : i == 1 ? 8'h1A : 8'h12;
			bus(1'b1, uepc_pkg::ADDR_FRAME_START_THRESHOLD, {24'hFFFFFF, t});
			rd(uepc_pkg::ADDR_FRAME_START_THRESHOLD, {24'h0, t});
			p_left <= {8'h0, t} - 16'h1;
			idle(4);
			tx(4'h0, 2'h0, 3'b001);
			p_left <= {8'h0, t};
			idle(4);
			tx(4'h0, 2'h0, 3'b101);
			idle(5);
		end
		chk({31'h0, irq_o}, 32'h1);
		bus(1'b1, uepc_pkg::ADDR_IRQ_STATUS, 32'h7);
		bus(1'b1, uepc_pkg::ADDR_MODE_CONTROL, 32'h0);
		idle(2);
		chk({29'h0, irq_o, host_mode_o, low_speed_direct_o}, 32'h0);
		bus(1'b1, 8'h20, 32'hFF);
		rd(8'h20, 32'h0);
		idle(4);
		end_sim();
	end
endmodule
`default_nettype wire
